// ===== logic/mcg_pkg.sv
/*
  package for the metering compute/gain configuration block: register offsets,
  field positions, reset values, angle modes and gain codes.
  assumes a plain register port with 16-bit address and 16-bit data.
*/
package mcg_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam logic [15:0] COMP_MODE_ADDR = 16'he60e;
  localparam logic [15:0] GAIN_SEL_ADDR = 16'he60f;

  // ----------------------------------------------------------------------
  // computation mode fields
  // ----------------------------------------------------------------------
  localparam int TERM1_LSB = 0;
  localparam int TERM2_LSB = 3;
  localparam int TERM3_LSB = 6;
  localparam int ANGLE_LSB = 9;
  localparam int NOMINAL_VOLTAGE_VALUE_LSB = 11;
  localparam int FREQ_BIT = 14;
  localparam int CMODE_RSVD_BIT = 15;
  localparam logic [15:0] COMP_MODE_RESET = 16'h01ff;
  localparam logic [15:0] COMP_MODE_MASK = 16'h7fff;

  // ----------------------------------------------------------------------
  // gain fields
  // ----------------------------------------------------------------------
  localparam int IGAIN_LSB = 0;
  localparam int NGAIN_LSB = 3;
  localparam int VGAIN_LSB = 6;
  localparam logic [15:0] GAIN_RESET = 16'h0000;
  localparam logic [15:0] GAIN_MASK = 16'h01ff;

  typedef enum logic [1:0] {
    MCG_ANGLE_VI = 2'h0,
    MCG_ANGLE_VV = 2'h1,
    MCG_ANGLE_II = 2'h2,
    MCG_ANGLE_NONE = 2'h3
  } mcg_angle_type;

  // one-hot shift amount of a pga: gain 1, 2, 4, 8, 16
  localparam logic [4:0] SHIFT_X1 = 5'h01;
  localparam logic [4:0] SHIFT_X2 = 5'h02;
  localparam logic [4:0] SHIFT_X4 = 5'h04;
  localparam logic [4:0] SHIFT_X8 = 5'h08;
  localparam logic [4:0] SHIFT_X16 = 5'h10;

endpackage

// ===== logic/mcg_gain_decode.sv
/*
  decodes one three-bit pga code into a one-hot gain, registered.
  assumes the code is the next value of a register on the same clock.
*/
`timescale 1ns/1ps
module mcg_gain_decode (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [2:0] code_in,
  output logic [4:0] gain_onehot_out
);

  logic [4:0] gain_reg;
  logic [4:0] gain_next;

  always_comb begin
    case (code_in)
      3'h0: gain_next = mcg_pkg::SHIFT_X1;
      3'h1: gain_next = mcg_pkg::SHIFT_X2;
      3'h2: gain_next = mcg_pkg::SHIFT_X4;
      3'h3: gain_next = mcg_pkg::SHIFT_X8;
      3'h4: gain_next = mcg_pkg::SHIFT_X16;
      // reserved codes act as unity gain
      default: gain_next = mcg_pkg::SHIFT_X1;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      gain_reg <= mcg_pkg::SHIFT_X1;
    end else begin
      gain_reg <= gain_next;
    end
  end

  assign gain_onehot_out = gain_reg;

endmodule

// ===== logic/mcg_phase_sel.sv
/*
  per-phase voltage selection: measured rms or the nominal voltage value.
  assumes both inputs are on the core clock; result is registered.
*/
`timescale 1ns/1ps
module mcg_phase_sel (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic use_nominal_in,
  input wire logic [23:0] measured_rms_in,
  input wire logic [23:0] nominal_voltage_value_in,
  output logic [23:0] rms_used_out
);

  logic [23:0] rms_reg;
  logic [23:0] rms_next;

  always_comb begin
    rms_next = use_nominal_in ? nominal_voltage_value_in : measured_rms_in;
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rms_reg <= 24'h000000;
    end else begin
      rms_reg <= rms_next;
    end
  end

  assign rms_used_out = rms_reg;

endmodule

// ===== logic/mcg_config.sv
/*
  configuration registers of the metering compute path: computation mode
  and channel gain select, with decoded controls for the datapath.
  assumes a same-clock register port, read data one cycle after the strobe.
*/
// Notes on behaviour
// [RULE1] phase b bit adds b to third output
// [RULE2] phase c bit adds c to third output
// [RULE3] all three bits set sums all phases
// [RULE4] angle code 00 vi, 01 vv, 10 ii
// [RULE5] angle code 11 measures nothing
// [RULE6] phase a nominal off uses measured rms
// [RULE7] phase a nominal on substitutes nominal value
// [RULE8] phase b nominal enable like phase a
// [RULE9] phase c nominal enable like phase a
// [RULE10] software sets frequency bit for 60 hz
// [RULE11] reserved mode bit zero, no function
// [RULE12] current gain code selects 1 to 16
// [RULE13] reserved current codes give unity gain
// [RULE14] neutral gain code same mapping
// [RULE15] reserved neutral codes give unity gain
// [RULE16] voltage gain code selects 1 to 16
// [RULE17] reserved voltage codes give unity gain
// [RULE18] gain bits 15:9 reserved, zero
`timescale 1ns/1ps
module mcg_config (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [15:0] reg_rdata_out,
  input wire logic [23:0] nominal_voltage_value_in,
  input wire logic [23:0] phase_a_rms_in,
  input wire logic [23:0] phase_b_rms_in,
  input wire logic [23:0] phase_c_rms_in,
  output logic [2:0] third_output_phase_include_out,
  output logic third_output_sum_all_out,
  output logic [1:0] angle_measure_select_out,
  output logic angle_vi_en_out,
  output logic angle_vv_en_out,
  output logic angle_ii_en_out,
  output logic [2:0] nominal_voltage_use_out,
  output logic line_frequency_select_out,
  output logic [23:0] phase_a_rms_used_out,
  output logic [23:0] phase_b_rms_used_out,
  output logic [23:0] phase_c_rms_used_out,
  output logic [4:0] phase_current_gain_out,
  output logic [4:0] neutral_current_gain_out,
  output logic [4:0] phase_voltage_gain_out
);

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  logic [15:0] comp_mode_reg;
  logic [15:0] comp_mode_next;
  logic [15:0] gain_reg;
  logic [15:0] gain_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  always_comb begin
    comp_mode_next = comp_mode_reg;
    gain_next = gain_reg;
    rdata_next = 16'h0000;
    if (reg_write_in) begin
      if (reg_addr_in == mcg_pkg::COMP_MODE_ADDR) begin
        comp_mode_next = reg_wdata_in & mcg_pkg::COMP_MODE_MASK; // RULE11
      end
      if (reg_addr_in == mcg_pkg::GAIN_SEL_ADDR) begin
        gain_next = reg_wdata_in & mcg_pkg::GAIN_MASK; // RULE18
      end
    end
    if (reg_read_in) begin
      case (reg_addr_in)
        mcg_pkg::COMP_MODE_ADDR: rdata_next = comp_mode_reg;
        mcg_pkg::GAIN_SEL_ADDR: rdata_next = gain_reg;
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      comp_mode_reg <= mcg_pkg::COMP_MODE_RESET;
      gain_reg <= mcg_pkg::GAIN_RESET;
      rdata_reg <= 16'h0000;
    end else begin
      comp_mode_reg <= comp_mode_next;
      gain_reg <= gain_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_out = rdata_reg;

  // ----------------------------------------------------------------------
  // decoded mode controls
  // ----------------------------------------------------------------------
  logic [2:0] incl_reg;
  logic [2:0] incl_next;
  logic sum_all_reg;
  logic sum_all_next;
  logic [1:0] angle_reg;
  logic [1:0] angle_next;
  logic [2:0] angle_en_reg;
  logic [2:0] angle_en_next;
  logic [2:0] nominal_voltage_value_reg;
  logic [2:0] nominal_voltage_value_next;
  logic freq_reg;
  logic freq_next;

  always_comb begin
    incl_next = comp_mode_next[mcg_pkg::TERM3_LSB +: 3]; // RULE1 RULE2
    sum_all_next = &comp_mode_next[mcg_pkg::TERM3_LSB +: 3]; // RULE3
    angle_next = comp_mode_next[mcg_pkg::ANGLE_LSB +: 2];
    case (mcg_pkg::mcg_angle_type'(angle_next))
      mcg_pkg::MCG_ANGLE_VI: angle_en_next = 3'h1; // RULE4
      mcg_pkg::MCG_ANGLE_VV: angle_en_next = 3'h2; // RULE4
      mcg_pkg::MCG_ANGLE_II: angle_en_next = 3'h4; // RULE4
      default: angle_en_next = 3'h0; // RULE5
    endcase
    nominal_voltage_value_next = comp_mode_next[mcg_pkg::NOMINAL_VOLTAGE_VALUE_LSB +: 3]; // RULE6 RULE8 RULE9
    freq_next = comp_mode_next[mcg_pkg::FREQ_BIT]; // RULE10
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      incl_reg <= 3'h7;
      sum_all_reg <= 1'b1;
      angle_reg <= 2'h0;
      angle_en_reg <= 3'h1;
      nominal_voltage_value_reg <= 3'h0;
      freq_reg <= 1'b0;
    end else begin
      incl_reg <= incl_next;
      sum_all_reg <= sum_all_next;
      angle_reg <= angle_next;
      angle_en_reg <= angle_en_next;
      nominal_voltage_value_reg <= nominal_voltage_value_next;
      freq_reg <= freq_next;
    end
  end

  assign third_output_phase_include_out = incl_reg;
  assign third_output_sum_all_out = sum_all_reg;
  assign angle_measure_select_out = angle_reg;
  assign angle_vi_en_out = angle_en_reg[0];
  assign angle_vv_en_out = angle_en_reg[1];
  assign angle_ii_en_out = angle_en_reg[2];
  assign nominal_voltage_use_out = nominal_voltage_value_reg;
  assign line_frequency_select_out = freq_reg;

  // ----------------------------------------------------------------------
  // nominal voltage substitution per phase
  // ----------------------------------------------------------------------
  logic [23:0] meas [3];
  logic [23:0] used [3];

  assign meas[0] = phase_a_rms_in;
  assign meas[1] = phase_b_rms_in;
  assign meas[2] = phase_c_rms_in;

  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++) begin : g_phase
      mcg_phase_sel u_sel (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .use_nominal_in(comp_mode_reg[mcg_pkg::NOMINAL_VOLTAGE_VALUE_LSB + ph]), // RULE7
        .measured_rms_in(meas[ph]),
        .nominal_voltage_value_in(nominal_voltage_value_in),
        .rms_used_out(used[ph])
      );
    end
  endgenerate

  assign phase_a_rms_used_out = used[0];
  assign phase_b_rms_used_out = used[1];
  assign phase_c_rms_used_out = used[2];

  // ----------------------------------------------------------------------
  // pga gain decode
  // ----------------------------------------------------------------------
  mcg_gain_decode u_igain (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .code_in(gain_next[mcg_pkg::IGAIN_LSB +: 3]), // RULE12 RULE13
    .gain_onehot_out(phase_current_gain_out)
  );

  mcg_gain_decode u_ngain (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .code_in(gain_next[mcg_pkg::NGAIN_LSB +: 3]), // RULE14 RULE15
    .gain_onehot_out(neutral_current_gain_out)
  );

  mcg_gain_decode u_vgain (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .code_in(gain_next[mcg_pkg::VGAIN_LSB +: 3]), // RULE16 RULE17
    .gain_onehot_out(phase_voltage_gain_out)
  );

endmodule

// ===== tb/mcg_config_assertions.sv
/*
  checker for mcg_config: register writes against the decoded outputs.
  assumes it is bound to mcg_config and sees its ports only.
*/
`timescale 1ns/1ps
module mcg_config_assertions (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic [2:0] third_output_phase_include_out,
  input wire logic third_output_sum_all_out,
  input wire logic [1:0] angle_measure_select_out,
  input wire logic angle_vi_en_out,
  input wire logic angle_vv_en_out,
  input wire logic angle_ii_en_out,
  input wire logic [4:0] phase_current_gain_out,
  input wire logic [4:0] neutral_current_gain_out,
  input wire logic [4:0] phase_voltage_gain_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire wr_m = reg_write_in && reg_addr_in == mcg_pkg::COMP_MODE_ADDR;
  wire wr_g = reg_write_in && reg_addr_in == mcg_pkg::GAIN_SEL_ADDR;
  function automatic logic [4:0] gx(input logic [2:0] c);
    return (c > 3'h4) ? 5'h01 : 5'h01 << c;
  endfunction
  sequence s_rd_g;
    reg_read_in && reg_addr_in == mcg_pkg::GAIN_SEL_ADDR;
  endsequence
  property p_inc;
    wr_m |=> third_output_phase_include_out == $past(reg_wdata_in[8:6]);
  endproperty
  a_inc: assert property (p_inc) else $error("include bits wrong");
  property p_sum;
    third_output_sum_all_out == (third_output_phase_include_out == 3'h7);
  endproperty
  a_sum: assert property (p_sum) else $error("sum all wrong");
  property p_asel;
    wr_m |=> angle_measure_select_out == $past(reg_wdata_in[10:9]);
  endproperty
  a_asel: assert property (p_asel) else $error("angle code wrong");
  property p_amap;
    angle_measure_select_out != 2'h3 |-> {angle_vi_en_out, angle_vv_en_out,
      angle_ii_en_out} == 3'h4 >> angle_measure_select_out;
  endproperty
  a_amap: assert property (p_amap) else $error("angle mode wrong");
  property p_anone;
    angle_measure_select_out == 2'h3 |-> !angle_vi_en_out && !angle_vv_en_out && !angle_ii_en_out;
  endproperty
  a_anone: assert property (p_anone) else $error("angle not off");
  property p_igain;
    wr_g |=> phase_current_gain_out == gx($past(reg_wdata_in[2:0]));
  endproperty
  a_igain: assert property (p_igain) else $error("current gain wrong");
  property p_ngain;
    wr_g |=> neutral_current_gain_out == gx($past(reg_wdata_in[5:3]));
  endproperty
  a_ngain: assert property (p_ngain) else $error("neutral gain wrong");
  property p_vgain;
    wr_g |=> phase_voltage_gain_out == gx($past(reg_wdata_in[8:6]));
  endproperty
  a_vgain: assert property (p_vgain) else $error("voltage gain wrong");
  property p_rsvd;
    s_rd_g |=> reg_rdata_out[15:9] == 7'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved gain bits set");
endmodule
bind mcg_config mcg_config_assertions mcg_config_assertions_i (
  .core_clk_in,
  .sys_rst_in,
  .reg_addr_in,
  .reg_wdata_in,
  .reg_write_in,
  .reg_read_in,
  .reg_rdata_out,
  .third_output_phase_include_out,
  .third_output_sum_all_out,
  .angle_measure_select_out,
  .angle_vi_en_out,
  .angle_vv_en_out,
  .angle_ii_en_out,
  .phase_current_gain_out,
  .neutral_current_gain_out,
  .phase_voltage_gain_out
);

// ===== tb/mcg_config_test.sv
/*
  self-checking bench for mcg_config over its register port.
  assumes the package constants for addresses and reset values.
*/
`timescale 1ns/1ps
module mcg_config_test;
  logic clk = 1'b0;
  logic rst, ws, rs, sall, vi, vv, ii, frq;
  logic [15:0] addr, wd, rdata;
  logic [2:0] inc, nuse;
  logic [1:0] asel;
  logic [23:0] ua, ub, uc;
  logic [4:0] gi, gn, gv;
  int failures = 0;
  int num_checks = 0;
  localparam logic [23:0] NV = 24'h123456;
  localparam logic [23:0] PA = 24'h0a0a0a;
  localparam logic [23:0] PB = 24'h0b0b0b;
  localparam logic [23:0] PC = 24'h0c0c0c;
  localparam logic [15:0] MA = mcg_pkg::COMP_MODE_ADDR;
  localparam logic [15:0] GA = mcg_pkg::GAIN_SEL_ADDR;
  mcg_config mcg_config_i (
    .core_clk_in(clk),
    .sys_rst_in(rst),
    .reg_addr_in(addr),
    .reg_wdata_in(wd),
    .reg_write_in(ws),
    .reg_read_in(rs),
    .reg_rdata_out(rdata),
    .nominal_voltage_value_in(NV),
    .phase_a_rms_in(PA),
    .phase_b_rms_in(PB),
    .phase_c_rms_in(PC),
    .third_output_phase_include_out(inc),
    .third_output_sum_all_out(sall),
    .angle_measure_select_out(asel),
    .angle_vi_en_out(vi),
    .angle_vv_en_out(vv),
    .angle_ii_en_out(ii),
    .nominal_voltage_use_out(nuse),
    .line_frequency_select_out(frq),
    .phase_a_rms_used_out(ua),
    .phase_b_rms_used_out(ub),
    .phase_c_rms_used_out(uc),
    .phase_current_gain_out(gi),
    .neutral_current_gain_out(gn),
    .phase_voltage_gain_out(gv)
  );
  always #4 clk = ~clk;
  task automatic report_and_stop();
    if (failures == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // each bus task starts just after an edge and returns just after one
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    addr <= a;
    wd <= d;
    ws <= 1'b1;
    @(posedge clk);
    ws <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    addr <= a;
    rs <= 1'b1;
    @(posedge clk);
    rs <= 1'b0;
    #1;
    chk("rdata", 24'(e), 24'(rdata));
  endtask
  function automatic logic [4:0] gexp(input logic [2:0] c);
    return (c > 3'h4) ? 5'h01 : 5'h01 << c;
  endfunction
  task automatic t_reset();
    chk("include", 24'h7, 24'(inc));
    chk("angle", 24'h4, 24'({vi, vv, ii}));
    chk("gains", 24'h0421, 24'({gi, gn, gv}));
    chk("rms_a", PA, ua);
    rd(MA, mcg_pkg::COMP_MODE_RESET);
    rd(GA, 16'h0000);
  endtask
  task automatic t_mode_all();
    wr(MA, 16'hffff);
    chk("angle_off", 24'h0, 24'({vi, vv, ii}));
    chk("freq", 24'h1, 24'(frq));
    @(posedge clk);
    #1;
    chk("nom_use", 24'h7, 24'(nuse));
    chk("rms_used_a", NV, ua);
    chk("rms_used_b", NV, ub);
    chk("rms_used_c", NV, uc);
    rd(MA, 16'h7fff);
  endtask
  task automatic t_angle();
    for (int i = 0; i < 4; i++) begin
      wr(MA, {5'h00, 2'(i), 9'h080});
      chk("include_b", 24'h2, 24'({sall, inc}));
      chk("angle", 24'((i == 3) ? 3'h0 : 3'h4 >> i), 24'({vi, vv, ii}));
    end
    @(posedge clk);
    #1;
    chk("nom_off", 24'h0, 24'(nuse));
    chk("rms_meas_a", PA, ua);
    chk("rms_meas_b", PB, ub);
    chk("rms_meas_c", PC, uc);
  endtask
  task automatic t_gain();
    logic [2:0] p, n, v;
    for (int c = 0; c < 8; c++) begin
      p = 3'(c);
      n = 3'(c + 1);
      v = 3'(c + 2);
      wr(GA, {7'h7f, v, n, p});
      chk("gains", 24'({gexp(p), gexp(n), gexp(v)}), 24'({gi, gn, gv}));
      rd(GA, {7'h00, v, n, p});
    end
  endtask
  task automatic t_unmapped();
    wr(16'he610, 16'hffff);
    rd(MA, 16'h0680);
    rd(GA, 16'h0047);
    rd(16'he610, 16'h0000);
    rd(MA, 16'h0680);
    @(posedge clk);
    #1;
    chk("rdata_idle", 24'h0, 24'(rdata));
  endtask
  initial begin
    #100000;
    failures++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    addr = 16'h0000;
    wd = 16'h0000;
    ws = 1'b0;
    rs = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_mode_all();
    t_angle();
    t_gain();
    t_unmapped();
    report_and_stop();
  end
endmodule
